//--- rtl/pdcs_pkg.sv
// package: register map, field layouts and timing constants of the pll control
package pdcs_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned LOCK_BASE_US    = 150;
  localparam int unsigned LOCK_BASE_CYC   = (LOCK_BASE_US * (CLK_HZ / 1_000_000));
  localparam int unsigned LOCK_REF_CYCLES = 256;
  localparam int unsigned INT_REF_HZ      = 1_000_000;
  localparam int unsigned REF_WIDTH_CYC   = CLK_HZ / INT_REF_HZ;

  localparam logic [7:0] ADDR_MULT   = 8'h00;
  localparam logic [7:0] ADDR_REF    = 8'h04;
  localparam logic [7:0] ADDR_POST   = 8'h08;
  localparam logic [7:0] ADDR_CTRL   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FREQ   = 8'h14;

  localparam int unsigned CTRL_PLL_ON  = 0;
  localparam int unsigned CTRL_SEL     = 1;
  localparam int unsigned CTRL_XOSC    = 2;
  localparam int unsigned CTRL_VARIANT = 3;
  localparam int unsigned ST_LOCK      = 0;
  localparam int unsigned ST_BUS_PLL   = 1;
  localparam int unsigned ST_BAND_ERR  = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] BAND_LOW  = 2'h0;
  localparam logic [1:0] BAND_MID  = 2'h1;
  localparam logic [1:0] BAND_RSVD = 2'h2;
  localparam logic [1:0] BAND_HIGH = 2'h3;
  localparam logic [31:0] BAND_LOW_MIN  = 32'h01e8_4800;
  localparam logic [31:0] BAND_LOW_MAX  = 32'h02dc_6c00;
  localparam logic [31:0] BAND_MID_MAX  = 32'h04c4_b400;
  localparam logic [31:0] BAND_HIGH_MAX = 32'h0727_0e00;

  typedef enum logic [1:0] {
    PDCS_IDLE,
    PDCS_ACQUIRE,
    PDCS_LOCKED
  } pdcs_lock_e;

  typedef struct packed {
    logic [1:0] vco_gain_band;
    logic [5:0] loop_multiplier;
  } pdcs_mult_s;

  typedef struct packed {
    logic [1:0] ref_filter_band;
    logic [5:0] reference_divider;
  } pdcs_ref_s;

  typedef struct packed {
    logic [31:0] vco_hz;
    logic [31:0] ref_hz;
    logic [31:0] pll_hz;
    logic [31:0] bus_hz;
  } pdcs_freq_s;
endpackage

//--- rtl/pdcs_pll_ctrl.sv
// pll divider and clock source control with an axi4-lite register slave
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module pdcs_pll_ctrl
  import pdcs_pkg::*;
#(
  parameter logic [31:0] OSC_HZ = 32'd8_000_000
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output pdcs_pkg::pdcs_freq_s   freq,
  output logic                   pll_locked,
  output logic                   bus_from_pll
);
  import pdcs_pkg::*;

  // ==========================================================
  // register slave
  pdcs_mult_s   mult_q, mult_d;
  pdcs_ref_s    refd_q, refd_d;
  logic [5:0]   post_q, post_d;
  logic [3:0]   ctrl_q, ctrl_d;
  logic         aw_q, aw_d, w_q, w_d;
  logic [7:0]   awaddr_q, awaddr_d;
  logic [31:0]  wdata_q, wdata_d;
  logic [3:0]   wstrb_q, wstrb_d;
  logic         bvalid_q, bvalid_d;
  logic [1:0]   bresp_q, bresp_d;
  logic         rvalid_q, rvalid_d;
  logic [1:0]   rresp_q, rresp_d;
  logic [31:0]  rdata_q, rdata_d;
  logic [31:0]  status_w;
  logic         ok_w, rd_ok;
  logic [31:0]  rd_val;

  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready  = !w_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [31:0] d,
                                       input logic [3:0] be);
    merge = be[0] ? d[7:0] : old_v;
  endfunction

  always_comb begin
    mult_d   = mult_q;
    refd_d   = refd_q;
    post_d   = post_q;
    ctrl_d   = ctrl_q;
    aw_d     = aw_q || (s_axi_awvalid && s_axi_awready);
    w_d      = w_q || (s_axi_wvalid && s_axi_wready);
    awaddr_d = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_q;
    wdata_d  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_q;
    wstrb_d  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d  = bresp_q;
    ok_w     = 1'b1;
    if (aw_q && w_q) begin
      aw_d     = 1'b0;
      w_d      = 1'b0;
      bvalid_d = 1'b1;
      unique case (awaddr_q)
        ADDR_MULT:   mult_d = merge(mult_q, wdata_q, wstrb_q);
        ADDR_REF:    refd_d = merge(refd_q, wdata_q, wstrb_q);
        ADDR_POST:   post_d = 6'(merge({2'h0, post_q}, wdata_q, wstrb_q));
        ADDR_CTRL:   ctrl_d = 4'(merge({4'h0, ctrl_q}, wdata_q, wstrb_q));
        ADDR_STATUS, ADDR_FREQ: ok_w = 1'b1;
        default:     ok_w = 1'b0;
      endcase
      bresp_d = ok_w ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0;
    unique case (s_axi_araddr)
      ADDR_MULT:   rd_val = {24'h0, mult_q};
      ADDR_REF:    rd_val = {24'h0, refd_q};
      ADDR_POST:   rd_val = {26'h0, post_q};
      ADDR_CTRL:   rd_val = {28'h0, ctrl_q};
      ADDR_STATUS: rd_val = status_w;
      ADDR_FREQ:   rd_val = freq.bus_hz;
      default:     rd_ok  = 1'b0;
    endcase
    rvalid_d = rvalid_q ? !s_axi_rready : s_axi_arvalid;
    rdata_d  = (s_axi_arvalid && s_axi_arready) ? rd_val : rdata_q;
    rresp_d  = (s_axi_arvalid && s_axi_arready)
               ? (rd_ok ? RESP_OKAY : RESP_SLVERR) : rresp_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mult_q   <= '0;
      refd_q   <= '0;
      post_q   <= '0;
      ctrl_q   <= '0;
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0;
    end else begin
      mult_q   <= mult_d;
      refd_q   <= refd_d;
      post_q   <= post_d;
      ctrl_q   <= ctrl_d;
      aw_q     <= aw_d;
      w_q      <= w_d;
      awaddr_q <= awaddr_d;
      wdata_q  <= wdata_d;
      wstrb_q  <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  // ==========================================================
  // frequency model
  // computed from settings; every division, the bus halving included, truncates to integer Hz
  logic [31:0] ref_hz, vco_hz, pll_hz;
  logic        band_err;
  pdcs_lock_e  st_q, st_d;
  logic [31:0] cnt_q, cnt_d, lock_cyc;

  always_comb begin
    if (ctrl_q[CTRL_XOSC] || !ctrl_q[CTRL_VARIANT])
      ref_hz = OSC_HZ / (32'(refd_q.reference_divider) + 32'd1);
    else
      ref_hz = 32'(INT_REF_HZ);
    vco_hz = 32'd2 * ref_hz * (32'(mult_q.loop_multiplier) + 32'd1);
    if (!ctrl_q[CTRL_VARIANT])
      pll_hz = (post_q == 6'h0) ? vco_hz
               : vco_hz / (32'd2 * 32'(post_q));
    else if (st_q == PDCS_LOCKED)
      pll_hz = vco_hz / (32'(post_q) + 32'd1);
    else
      pll_hz = vco_hz / 32'd4;
    unique case (mult_q.vco_gain_band)
      BAND_LOW:  band_err = vco_hz < BAND_LOW_MIN || vco_hz > BAND_LOW_MAX;
      BAND_MID:  band_err = vco_hz <= BAND_LOW_MAX || vco_hz > BAND_MID_MAX;
      BAND_HIGH: band_err = vco_hz <= BAND_MID_MAX || vco_hz > BAND_HIGH_MAX;
      BAND_RSVD: band_err = 1'b1;
    endcase
  end

  // ==========================================================
  // lock sequencer
  // lock takes 150 us plus 256 ref periods, each truncated to whole clock cycles; a bad band never locks
  assign lock_cyc = 32'(LOCK_BASE_CYC)
                    + 32'(LOCK_REF_CYCLES) * (32'(CLK_HZ) / ref_hz);

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      PDCS_IDLE: begin
        cnt_d = 32'h0;
        if (ctrl_q[CTRL_PLL_ON]) st_d = PDCS_ACQUIRE;
      end
      PDCS_ACQUIRE: begin
        cnt_d = cnt_q + 32'd1;
        if (!ctrl_q[CTRL_PLL_ON] || band_err) begin
          st_d  = PDCS_IDLE;
        end else if (cnt_q + 32'd1 >= lock_cyc) begin
          st_d = PDCS_LOCKED;
        end
      end
      PDCS_LOCKED: begin
        if (!ctrl_q[CTRL_PLL_ON] || band_err) st_d = PDCS_IDLE;
      end
      default: st_d = PDCS_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q  <= PDCS_IDLE;
      cnt_q <= 32'h0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // ==========================================================
  // bus clock source
  logic        sel_pll_q, sel_pll_d;
  pdcs_freq_s  freq_q, freq_d;

  always_comb begin
    sel_pll_d = ctrl_q[CTRL_SEL] && (st_q == PDCS_LOCKED);
    freq_d.vco_hz = vco_hz;
    freq_d.ref_hz = ref_hz;
    freq_d.pll_hz = pll_hz;
    freq_d.bus_hz = sel_pll_d ? pll_hz >> 1 : OSC_HZ >> 1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_pll_q <= 1'b0;
      freq_q    <= '0;
    end else begin
      sel_pll_q <= sel_pll_d;
      freq_q    <= freq_d;
    end
  end

  assign freq         = freq_q;
  assign pll_locked   = (st_q == PDCS_LOCKED);
  assign bus_from_pll = sel_pll_q;
  assign status_w     = {29'h0, band_err, sel_pll_q, pll_locked};

  a_bus_needs_lock: assert property (
    @(posedge aclk) disable iff (!aresetn)
    bus_from_pll |-> $past(pll_locked))
    else $error("bus on pll without lock");
  a_bus_half_pll: assert property (
    @(posedge aclk) disable iff (!aresetn)
    bus_from_pll |-> freq.bus_hz == $past(pll_hz) >> 1)
    else $error("bus not half pll");
  a_unlock_div4: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_q[CTRL_VARIANT] && !pll_locked)
      |=> freq.pll_hz == $past(vco_hz) / 4)
    else $error("unlocked pll not vco over four");
  a_internal_ref: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ctrl_q[CTRL_VARIANT] && !ctrl_q[CTRL_XOSC])
      |=> freq.ref_hz == INT_REF_HZ)
    else $error("internal reference not 1 MHz");
  a_reserved_band: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (mult_q.vco_gain_band == BAND_RSVD) |=> !pll_locked)
    else $error("locked with reserved band");
  a_lock_bound: assert property (
    @(posedge aclk) disable iff (!aresetn)
    pll_locked && !$past(pll_locked) |-> $past(cnt_q) + 1 >= $past(lock_cyc))
    else $error("lock before worst case");
endmodule

//--- verification/testbench.sv
// self-checking bench for the pll divider and clock source control
`timescale 1ns/1ns
module testbench;
  import pdcs_pkg::*;
  // ==========================================================
  // signals
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        pll_locked, bus_from_pll;
  pdcs_freq_s  freq;
  int          errors, n_compared;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          cyc;
  pdcs_pll_ctrl i_pdcs_pll_ctrl (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .freq(freq), .pll_locked(pll_locked),
    .bus_from_pll(bus_from_pll));
  // ==========================================================
  // helpers
  task automatic conclude();
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // handshakes judged at the falling edge, released at the next rising
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_ok, w_ok, b_ok;
    n = 0;
    b_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok && n < 50) begin
      @(negedge aclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!b_ok) begin
      errors++;
      conclude();
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    logic ar_ok, r_ok;
    n = 0;
    r_ok = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok && n < 50) begin
      @(negedge aclk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!r_ok) begin
      errors++;
      conclude();
    end
  endtask
  // lock is looked at on the falling edge, clear of the launching edge
  task automatic wait_lock(input int lim);
    cyc = 0;
    while (pll_locked !== 1'b1 && cyc < lim) begin
      @(negedge aclk);
      cyc++;
    end
    if (pll_locked !== 1'b1) begin
      errors++;
      conclude();
    end
    repeat (3) @(negedge aclk);
  endtask
  // ==========================================================
  // scenarios
  // worst-case lock bounds: 256 periods of an 8 MHz ref is 320 cycles
  task automatic s_variant_one();
    wr(ADDR_MULT, 32'h01);
    wr(ADDR_REF, 32'h00);
    wr(ADDR_POST, 32'h01);
    wr(ADDR_CTRL, 32'h05);
    repeat (3) @(negedge aclk);
    chk("vco", 32'd32_000_000, freq.vco_hz);
    chk("ref", 32'd8_000_000, freq.ref_hz);
    chk("pll", 32'd16_000_000, freq.pll_hz);
    chk("bus_osc", 32'd4_000_000, freq.bus_hz);
    wait_lock(LOCK_BASE_CYC + LOCK_REF_CYCLES * 10 / 8);
    wr(ADDR_CTRL, 32'h07);
    chk("bresp_ok", {30'h0, RESP_OKAY}, {30'h0, rs});
    repeat (3) @(negedge aclk);
    chk("bus_pll", 32'd8_000_000, freq.bus_hz);
    chk("from_pll", 32'h1, {31'h0, bus_from_pll});
    rdr(ADDR_FREQ);
    chk("freq_reg", 32'd8_000_000, rd);
    chk("rresp_ok", {30'h0, RESP_OKAY}, {30'h0, rs});
    rdr(ADDR_STATUS);
    chk("status", 32'h3, rd & 32'h7);
  endtask
  task automatic s_variant_two();
    wr(ADDR_CTRL, 32'h00);
    wr(ADDR_POST, 32'h01);
    wr(ADDR_CTRL, 32'h0d);
    repeat (3) @(negedge aclk);
    chk("pll_unlk", 32'd8_000_000, freq.pll_hz);
    wait_lock(LOCK_BASE_CYC + LOCK_REF_CYCLES * 10 / 8);
    chk("pll_lk", 32'd16_000_000, freq.pll_hz);
    wr(ADDR_POST, 32'h00);
    repeat (3) @(negedge aclk);
    chk("pll_post0", 32'd32_000_000, freq.pll_hz);
  endtask
  task automatic s_internal();
    wr(ADDR_CTRL, 32'h00);
    wr(ADDR_REF, 32'h03);
    wr(ADDR_MULT, 32'h0f);
    wr(ADDR_CTRL, 32'h09);
    repeat (3) @(negedge aclk);
    chk("ref_int", 32'd1_000_000, freq.ref_hz);
    chk("vco_int", 32'd32_000_000, freq.vco_hz);
    wait_lock(LOCK_BASE_CYC + LOCK_REF_CYCLES * 10);
    wr(ADDR_CTRL, 32'h0d);
    repeat (3) @(negedge aclk);
    chk("ref_ext", 32'd2_000_000, freq.ref_hz);
  endtask
  // every band code against low, mid and high vco on the 1 MHz reference
  task automatic s_bands();
    logic [31:0] v;
    logic        ok;
    wr(ADDR_CTRL, 32'h0b);
    for (int b = 0; b < 4; b++) begin
      for (int m = 15; m < 48; m += 16) begin
        v = 32'd2_000_000 * (m + 1);
        ok = (b == 0 && v >= 32'd32_000_000 && v <= 32'd48_000_000) ||
             (b == 1 && v > 32'd48_000_000 && v <= 32'd80_000_000) ||
             (b == 3 && v > 32'd80_000_000 && v <= 32'd120_000_000);
        wr(ADDR_MULT, {24'h0, b[1:0], m[5:0]});
        repeat (3) @(negedge aclk);
        rdr(ADDR_STATUS);
        chk("band_err", {31'h0, !ok}, {31'h0, rd[ST_BAND_ERR]});
      end
    end
    // wrong band keeps the loop unlocked, so the bus stays on the oscillator
    wr(ADDR_MULT, 32'hcf);
    repeat (5000) @(negedge aclk);
    chk("no_lock", 32'h0, {31'h0, pll_locked});
    chk("sel_unlk", 32'h0, {31'h0, bus_from_pll});
    chk("bus_unlk", 32'd4_000_000, freq.bus_hz);
  endtask
  task automatic s_unmapped();
    rdr(8'h20);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    wr(8'h24, 32'h5a);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    // read-only words take a write quietly
    wr(ADDR_STATUS, 32'h7);
    chk("bresp_ro", {30'h0, RESP_OKAY}, {30'h0, rs});
  endtask
  // ==========================================================
  // clock, reset, sequence
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    errors = 0;
    n_compared = 0;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    s_unmapped();
    s_variant_one();
    s_variant_two();
    s_internal();
    s_bands();
    conclude();
  end
endmodule
